// ---- bwsr_pkg.sv ----
/*
 * Constants, types and register map for the bridge window and secondary
 * status register bank.
 * Assumes a 32-bit AXI4-Lite register bus with 12-bit byte addresses; each
 * register sits in the low bits of its own aligned word.
 */
// Notes on behaviour
// R1 - Top register bit 0 mirrors floor capability
// R2 - I/O top field bits 7:4, reset zero
// R3 - I/O floor/top decide I/O forwarding
// R4 - System-error flag stays clear while reporting disabled
// R5 - ERR message sets system-error flag; write-one clears
// R6 - Poisoned secondary TLP sets parity flag; write-one clears
// R7 - Parity flag ignores parity response enable
// R8 - Secondary status bits 13:0 read zero
// R9 - Memory floor bits 15:4, reset all ones
// R10 - Memory floor/top decide memory forwarding
// R11 - Capability 0=16-bit, 1=32-bit; writable when unlocked
// R12 - I/O floor field A[15:12], reset 0xF
// R13 - Memory top field A[31:20], low bits ones
// R14 - Reserved bits read zero, writes ignored
// R15 - Window inclusive both ends; floor above top empties
package bwsr_pkg;

	localparam int BWSR_AW = 12;

	// Printed offsets are register indices; byte address is four times
	localparam logic [7:0] BWSR_IDX_IO_FLOOR = 8'h1c;
	localparam logic [7:0] BWSR_IDX_IO_TOP = 8'h1d;
	localparam logic [7:0] BWSR_IDX_SEC_STS = 8'h1e;
	localparam logic [7:0] BWSR_IDX_MEM_FLOOR = 8'h20;
	localparam logic [7:0] BWSR_IDX_MEM_TOP = 8'h22;
	localparam logic [11:0] BWSR_A_IO_FLOOR = {2'h0, BWSR_IDX_IO_FLOOR, 2'h0};
	localparam logic [11:0] BWSR_A_IO_TOP = {2'h0, BWSR_IDX_IO_TOP, 2'h0};
	localparam logic [11:0] BWSR_A_SEC_STS = {2'h0, BWSR_IDX_SEC_STS, 2'h0};
	localparam logic [11:0] BWSR_A_MEM_FLOOR = {2'h0, BWSR_IDX_MEM_FLOOR, 2'h0};
	localparam logic [11:0] BWSR_A_MEM_TOP = {2'h0, BWSR_IDX_MEM_TOP, 2'h0};
	localparam logic [11:0] BWSR_A_CTRL = 12'h100;
	localparam logic [11:0] BWSR_A_INT_STAT = 12'h104;
	localparam logic [11:0] BWSR_A_INT_MASK = 12'h108;

	// Field positions
	localparam int BWSR_IO_CAP_BIT = 0;
	localparam int BWSR_IO_FIELD_LSB = 4;
	localparam int BWSR_MEM_FIELD_LSB = 4;
	localparam int BWSR_RSE_BIT = 14;
	localparam int BWSR_DPE_BIT = 15;
	localparam int BWSR_CTRL_SERR_BIT = 0;
	localparam int BWSR_CTRL_PERR_BIT = 1;
	localparam int BWSR_CTRL_UNLOCK_BIT = 2;
	localparam int BWSR_INT_RSE_BIT = 0;
	localparam int BWSR_INT_DPE_BIT = 1;

	// Values after reset
	localparam logic BWSR_IO_CAP_RST = 1'h1;
	localparam logic [3:0] BWSR_IO_FLOOR_RST = 4'hf;
	localparam logic [3:0] BWSR_IO_TOP_RST = 4'h0;
	localparam logic [11:0] BWSR_MEM_FLOOR_RST = 12'hfff;
	localparam logic [11:0] BWSR_MEM_TOP_RST = 12'h000;
	localparam logic [1:0] BWSR_INT_MASK_RST = 2'h0;

	// Implied low address bits of a window top
	localparam logic [11:0] BWSR_IO_LOW_ONES = 12'hfff;
	localparam logic [19:0] BWSR_MEM_LOW_ONES = 20'hf_ffff;

	localparam logic [1:0] BWSR_RESP_OKAY = 2'h0;
	localparam logic [1:0] BWSR_RESP_SLVERR = 2'h2;

	typedef enum {
		BWSR_SEL_IO_FLOOR,
		BWSR_SEL_IO_TOP,
		BWSR_SEL_SEC_STS,
		BWSR_SEL_MEM_FLOOR,
		BWSR_SEL_MEM_TOP,
		BWSR_SEL_CTRL,
		BWSR_SEL_INT_STAT,
		BWSR_SEL_INT_MASK,
		BWSR_SEL_NONE
	} bwsr_sel_e;

	typedef struct packed {
		logic cap_unlock;
		logic perr_en;
		logic serr_en;
	} bwsr_ctrl_s;

	typedef struct packed {
		logic [31:0] floor;
		logic [31:0] top;
	} bwsr_win_s;

endpackage

// ---- bwsr_window_cmp.sv ----
/*
 * Inclusive window compare for one forwarding window.
 * Assumes floor and top are already expanded to full byte addresses.
 */
module bwsr_window_cmp (
	// Window bounds
	input wire bwsr_pkg::bwsr_win_s win,
	// Address under test
	input wire logic [31:0] addr,
	// Result
	output logic hit
);
	import bwsr_pkg::*;

	// A floor above the top can never satisfy both bounds, so it is empty
	assign hit = (addr >= win.floor) && (addr <= win.top); // R15
endmodule

// ---- bwsr_regs.sv ----
/*
 * Bridge I/O window, secondary status and memory window register bank,
 * with forwarding decisions, event flags and one interrupt output.
 * Assumes an AXI4-Lite master on CLK_SYS; event inputs and lookup addresses
 * come from logic on the same clock.
 */
module bwsr_regs (
	// Clock, reset, enable
	input wire logic CLK_SYS,
	input wire logic RESETN,
	input wire logic CE,
	// AXI4-Lite write address and data
	input wire logic [bwsr_pkg::BWSR_AW-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	// AXI4-Lite write response
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// AXI4-Lite read
	input wire logic [bwsr_pkg::BWSR_AW-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// Secondary side events
	input wire logic ERR_MSG_RX,
	input wire logic POISON_RX,
	// Forwarding lookups
	input wire logic [31:0] IO_REQ_ADDR,
	input wire logic [31:0] MEM_REQ_ADDR,
	output logic IO_FWD,
	output logic MEM_FWD,
	// Interrupt
	output logic IRQ
);
	import bwsr_pkg::*;

	logic aw_held;
	logic w_held;
	logic [BWSR_AW-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_do;
	bwsr_sel_e wr_sel;
	bwsr_sel_e rd_sel;
	logic [31:0] rd_word;
	logic io_cap;
	logic [3:0] io_floor;
	logic [3:0] io_top;
	logic [11:0] mem_floor;
	logic [11:0] mem_top;
	logic received_system_error_flag;
	logic detected_parity_error_flag;
	bwsr_ctrl_s ctrl;
	logic [1:0] int_stat;
	logic [1:0] int_mask;
	logic [1:0] next_int_stat;
	logic rse_set;
	logic rse_clr;
	logic dpe_clr;
	bwsr_win_s io_win;
	bwsr_win_s mem_win;
	logic io_hit;
	logic mem_hit;

	// Address decode, shared by the read and the write path
	function automatic bwsr_sel_e reg_decode(input logic [BWSR_AW-1:0] a);
		unique case (a)
			BWSR_A_IO_FLOOR: reg_decode = BWSR_SEL_IO_FLOOR;
			BWSR_A_IO_TOP: reg_decode = BWSR_SEL_IO_TOP;
			BWSR_A_SEC_STS: reg_decode = BWSR_SEL_SEC_STS;
			BWSR_A_MEM_FLOOR: reg_decode = BWSR_SEL_MEM_FLOOR;
			BWSR_A_MEM_TOP: reg_decode = BWSR_SEL_MEM_TOP;
			BWSR_A_CTRL: reg_decode = BWSR_SEL_CTRL;
			BWSR_A_INT_STAT: reg_decode = BWSR_SEL_INT_STAT;
			BWSR_A_INT_MASK: reg_decode = BWSR_SEL_INT_MASK;
			default: reg_decode = BWSR_SEL_NONE;
		endcase
	endfunction

	assign wr_sel = reg_decode(aw_addr);
	assign rd_sel = reg_decode(S_AXI_ARADDR);
	// Write happens once both halves are held and no response is pending
	assign wr_do = CE && aw_held && w_held && !S_AXI_BVALID;

	// Write address channel; address and data may arrive in either order
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
			S_AXI_AWREADY <= 1'b0;
		end else if (CE) begin
			if (S_AXI_AWREADY && S_AXI_AWVALID) begin
				aw_held <= 1'b1;
				aw_addr <= S_AXI_AWADDR;
				S_AXI_AWREADY <= 1'b0;
			end else if (S_AXI_BVALID && S_AXI_BREADY) begin
				aw_held <= 1'b0;
				S_AXI_AWREADY <= 1'b1;
			end else if (!aw_held && !S_AXI_BVALID) begin
				S_AXI_AWREADY <= 1'b1;
			end
		end
	end

	// Write data channel
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			w_held <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
			S_AXI_WREADY <= 1'b0;
		end else if (CE) begin
			if (S_AXI_WREADY && S_AXI_WVALID) begin
				w_held <= 1'b1;
				w_data <= S_AXI_WDATA;
				w_strb <= S_AXI_WSTRB;
				S_AXI_WREADY <= 1'b0;
			end else if (S_AXI_BVALID && S_AXI_BREADY) begin
				w_held <= 1'b0;
				S_AXI_WREADY <= 1'b1;
			end else if (!w_held && !S_AXI_BVALID) begin
				S_AXI_WREADY <= 1'b1;
			end
		end
	end

	// Write response; unmapped addresses answer SLVERR and change nothing
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= BWSR_RESP_OKAY;
		end else if (CE) begin
			if (wr_do) begin
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= (wr_sel == BWSR_SEL_NONE) ?
					BWSR_RESP_SLVERR : BWSR_RESP_OKAY;
			end else if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	// Read value; everything not listed reads as zero
	always_comb begin
		rd_word = '0;
		unique case (rd_sel)
			BWSR_SEL_IO_FLOOR: begin
				rd_word[BWSR_IO_CAP_BIT] = io_cap;
				rd_word[BWSR_IO_FIELD_LSB +: 4] = io_floor;
			end
			BWSR_SEL_IO_TOP: begin
				rd_word[BWSR_IO_CAP_BIT] = io_cap; // R1
				rd_word[BWSR_IO_FIELD_LSB +: 4] = io_top; // R2
			end
			BWSR_SEL_SEC_STS: begin
				// Bits 13:0 stay at their zero default
				rd_word[BWSR_RSE_BIT] = received_system_error_flag; // R8
				rd_word[BWSR_DPE_BIT] = detected_parity_error_flag;
			end
			BWSR_SEL_MEM_FLOOR: rd_word[BWSR_MEM_FIELD_LSB +: 12] = mem_floor; // R9
			BWSR_SEL_MEM_TOP: rd_word[BWSR_MEM_FIELD_LSB +: 12] = mem_top;
			BWSR_SEL_CTRL: begin
				rd_word[BWSR_CTRL_SERR_BIT] = ctrl.serr_en;
				rd_word[BWSR_CTRL_PERR_BIT] = ctrl.perr_en;
				rd_word[BWSR_CTRL_UNLOCK_BIT] = ctrl.cap_unlock;
			end
			BWSR_SEL_INT_STAT: rd_word[1:0] = int_stat;
			BWSR_SEL_INT_MASK: rd_word[1:0] = int_mask;
			BWSR_SEL_NONE: rd_word = '0; // R14
		endcase
	end

	// Read channel; one read in flight, data captured at the address edge
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= '0;
			S_AXI_RRESP <= BWSR_RESP_OKAY;
		end else if (CE) begin
			if (S_AXI_ARREADY && S_AXI_ARVALID) begin
				S_AXI_ARREADY <= 1'b0;
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA <= rd_word;
				S_AXI_RRESP <= (rd_sel == BWSR_SEL_NONE) ?
					BWSR_RESP_SLVERR : BWSR_RESP_OKAY;
			end else if (S_AXI_RVALID && S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
				S_AXI_ARREADY <= 1'b1;
			end else if (!S_AXI_RVALID) begin
				S_AXI_ARREADY <= 1'b1;
			end
		end
	end

	// I/O window fields; the capability bit is guarded so a stray write
	// cannot flip the addressing width under running software
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			io_cap <= BWSR_IO_CAP_RST;
			io_floor <= BWSR_IO_FLOOR_RST; // R12
			io_top <= BWSR_IO_TOP_RST; // R2
		end else if (wr_do && w_strb[0]) begin
			if (wr_sel == BWSR_SEL_IO_FLOOR) begin
				if (ctrl.cap_unlock)
					io_cap <= w_data[BWSR_IO_CAP_BIT]; // R11
				io_floor <= w_data[BWSR_IO_FIELD_LSB +: 4]; // R12
			end
			if (wr_sel == BWSR_SEL_IO_TOP)
				io_top <= w_data[BWSR_IO_FIELD_LSB +: 4]; // R2
		end
	end

	// Memory window fields span both low byte lanes
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			mem_floor <= BWSR_MEM_FLOOR_RST; // R9
			mem_top <= BWSR_MEM_TOP_RST;
		end else if (wr_do) begin
			if (wr_sel == BWSR_SEL_MEM_FLOOR) begin
				if (w_strb[0])
					mem_floor[3:0] <= w_data[7:4]; // R9
				if (w_strb[1])
					mem_floor[11:4] <= w_data[15:8];
			end
			if (wr_sel == BWSR_SEL_MEM_TOP) begin
				if (w_strb[0])
					mem_top[3:0] <= w_data[7:4]; // R13
				if (w_strb[1])
					mem_top[11:4] <= w_data[15:8];
			end
		end
	end

	// Control bits: error report enable, parity response enable, unlock
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			ctrl <= '0;
		end else if (wr_do && w_strb[0] && wr_sel == BWSR_SEL_CTRL) begin
			ctrl.serr_en <= w_data[BWSR_CTRL_SERR_BIT];
			ctrl.perr_en <= w_data[BWSR_CTRL_PERR_BIT];
			ctrl.cap_unlock <= w_data[BWSR_CTRL_UNLOCK_BIT];
		end
	end

	assign rse_set = ctrl.serr_en && ERR_MSG_RX; // R4 R5
	assign rse_clr = wr_do && w_strb[1] && wr_sel == BWSR_SEL_SEC_STS &&
		w_data[BWSR_RSE_BIT];
	assign dpe_clr = wr_do && w_strb[1] && wr_sel == BWSR_SEL_SEC_STS &&
		w_data[BWSR_DPE_BIT];

	// Secondary status flags; a new event wins over a same-cycle clear
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			received_system_error_flag <= 1'b0;
			detected_parity_error_flag <= 1'b0;
		end else if (CE) begin
			received_system_error_flag <= (received_system_error_flag && !rse_clr) || rse_set; // R5
			// Parity response enable deliberately not consulted
			detected_parity_error_flag <= (detected_parity_error_flag && !dpe_clr) || POISON_RX; // R6 R7
		end
	end

	// Interrupt status mirrors the two events, cleared by writing ones
	always_comb begin
		next_int_stat = int_stat;
		if (wr_do && w_strb[0] && wr_sel == BWSR_SEL_INT_STAT)
			next_int_stat = int_stat & ~w_data[1:0];
		next_int_stat[BWSR_INT_RSE_BIT] = next_int_stat[BWSR_INT_RSE_BIT] ||
			rse_set;
		next_int_stat[BWSR_INT_DPE_BIT] = next_int_stat[BWSR_INT_DPE_BIT] ||
			POISON_RX;
	end

	// Interrupt status, mask and output
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			int_stat <= '0;
			int_mask <= BWSR_INT_MASK_RST;
			IRQ <= 1'b0;
		end else if (CE) begin
			int_stat <= next_int_stat;
			if (wr_do && w_strb[0] && wr_sel == BWSR_SEL_INT_MASK)
				int_mask <= w_data[1:0];
			IRQ <= |(int_stat & int_mask);
		end
	end

	// Expanded windows; upper I/O bits are zero since no upper I/O
	// registers exist here, so 32-bit mode still decodes below 64K
	assign io_win.floor = {16'h0000, io_floor, 12'h000}; // R3
	assign io_win.top = {16'h0000, io_top, BWSR_IO_LOW_ONES};
	assign mem_win.floor = {mem_floor, 20'h0_0000}; // R10
	assign mem_win.top = {mem_top, BWSR_MEM_LOW_ONES}; // R13

	bwsr_window_cmp u_io_cmp (
		.win(io_win),
		.addr(IO_REQ_ADDR),
		.hit(io_hit)
	);

	bwsr_window_cmp u_mem_cmp (
		.win(mem_win),
		.addr(MEM_REQ_ADDR),
		.hit(mem_hit)
	);

	// Forwarding decisions, one cycle after the address is presented
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			IO_FWD <= 1'b0;
			MEM_FWD <= 1'b0;
		end else if (CE) begin
			IO_FWD <= io_hit; // R3
			MEM_FWD <= mem_hit; // R10
		end
	end

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RESETN);

	sequence s_err_masked;
		CE && ctrl.serr_en && ERR_MSG_RX && int_mask[BWSR_INT_RSE_BIT];
	endsequence

	sequence s_io_read;
		CE && S_AXI_ARREADY && S_AXI_ARVALID && rd_sel == BWSR_SEL_IO_TOP;
	endsequence

	sequence s_sec_read;
		CE && S_AXI_ARREADY && S_AXI_ARVALID && rd_sel == BWSR_SEL_SEC_STS;
	endsequence

	a_rse_gated_off: assert property ( // R4
		CE && !ctrl.serr_en && !received_system_error_flag |=> !received_system_error_flag)
		else $error("System error flag set while reporting disabled");

	a_rse_sets: assert property ( // R5
		CE && ctrl.serr_en && ERR_MSG_RX |=> received_system_error_flag)
		else $error("System error flag missed an error message");

	a_dpe_sets_always: assert property ( // R7
		CE && POISON_RX |=> detected_parity_error_flag)
		else $error("Parity flag missed a poisoned packet");

	a_dpe_w1c: assert property ( // R6
		dpe_clr && !POISON_RX |=> !detected_parity_error_flag)
		else $error("Parity flag not cleared by write of one");

	a_sec_low_zero: assert property ( // R8
		s_sec_read |=> S_AXI_RDATA[13:0] == 14'h0000)
		else $error("Secondary status low bits not zero");

	a_io_cap_mirror: assert property ( // R1
		s_io_read |=> S_AXI_RDATA[0] == $past(io_cap) &&
			S_AXI_RDATA[3:1] == 3'h0)
		else $error("Top register capability bit not mirrored");

	a_io_fwd_match: assert property ( // R15
		CE && IO_REQ_ADDR[31:16] == 16'h0000 &&
		IO_REQ_ADDR[15:12] >= io_floor && IO_REQ_ADDR[15:12] <= io_top
		|=> IO_FWD)
		else $error("I/O address inside window not forwarded");

	a_mem_fwd_miss: assert property ( // R10
		CE && MEM_REQ_ADDR[31:20] > mem_top |=> !MEM_FWD)
		else $error("Memory address above window forwarded");

	a_irq_path: assert property (
		s_err_masked ##1 CE |=> IRQ)
		else $error("Masked-in error did not raise interrupt");

	a_wr_answer: assert property (
		wr_do |=> S_AXI_BVALID && !S_AXI_AWREADY && !S_AXI_WREADY)
		else $error("Write not answered after both halves held");
endmodule

// ---- tb_bwsr_regs.sv ----
/*
 * Self-checking bench for the bridge window and secondary status bank.
 * Assumes bwsr_pkg and bwsr_regs are compiled first; the bench acts as
 * the AXI4-Lite master and drives the event and lookup inputs itself.
 */
`define CHK(nm, e, g) begin \
	n_checks++; \
	if ((g) !== (e)) begin \
		n_mismatch++; \
		$display("Error %s expected %h seen %h", nm, e, g); \
	end \
end

module tb_bwsr_regs;
	timeunit 1ns;
	timeprecision 1ns;
	import bwsr_pkg::*;

	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic ce = 1'b1;
	logic [BWSR_AW-1:0] awaddr = '0;
	logic awvalid = 1'b0;
	logic awready;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = '0;
	logic wvalid = 1'b0;
	logic wready;
	logic [1:0] bresp;
	logic bvalid;
	logic bready = 1'b0;
	logic [BWSR_AW-1:0] araddr = '0;
	logic arvalid = 1'b0;
	logic arready;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic rvalid;
	logic rready = 1'b0;
	logic err_msg = 1'b0;
	logic poison = 1'b0;
	logic [31:0] io_addr = '0;
	logic [31:0] mem_addr = '0;
	logic io_fwd;
	logic mem_fwd;
	logic irq;
	int n_mismatch = 0;
	int n_checks = 0;
	logic [31:0] rd;
	logic [1:0] rsp;

	// Free-running 20 MHz system clock
	always #25 clk_sys = ~clk_sys;

	bwsr_regs i_bwsr_regs (
		.CLK_SYS(clk_sys), .RESETN(resetn), .CE(ce),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
		.S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.ERR_MSG_RX(err_msg), .POISON_RX(poison),
		.IO_REQ_ADDR(io_addr), .MEM_REQ_ADDR(mem_addr),
		.IO_FWD(io_fwd), .MEM_FWD(mem_fwd), .IRQ(irq)
	);

	// Write: AW and W offered together, each released when taken
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
			input logic [3:0] s, output logic [1:0] r);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge clk_sys);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge clk_sys);
			if (!aw_done && awready === 1'b1) begin
				awvalid <= 1'b0;
				aw_done = 1'b1;
			end
			if (!w_done && wready === 1'b1) begin
				wvalid <= 1'b0;
				w_done = 1'b1;
			end
		end
		while (bvalid !== 1'b1) @(posedge clk_sys);
		r = bresp;
		bready <= 1'b0;
	endtask

	// Read: ARVALID held until taken, RREADY held until RVALID seen
	task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
			output logic [1:0] r);
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk_sys); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge clk_sys);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		axi_wr(a, d, 4'hf, rsp);
		`CHK("bresp", BWSR_RESP_OKAY, rsp)
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		axi_rd(a, rd, rsp);
		`CHK("rresp", BWSR_RESP_OKAY, rsp)
		`CHK("rdata", e, rd)
	endtask

	// One-cycle event strobe
	task automatic pulse(input bit is_err);
		@(posedge clk_sys);
		if (is_err) err_msg <= 1'b1;
		else poison <= 1'b1;
		@(posedge clk_sys);
		err_msg <= 1'b0;
		poison <= 1'b0;
	endtask

	task automatic fwd(input logic [31:0] ia, input logic [31:0] ma,
			input logic ei, input logic em);
		@(posedge clk_sys);
		io_addr <= ia;
		mem_addr <= ma;
		repeat (2) @(posedge clk_sys);
		#1;
		`CHK("io_fwd", ei, io_fwd)
		`CHK("mem_fwd", em, mem_fwd)
	endtask

	task automatic t_reset_vals;
		rd_chk(BWSR_A_IO_FLOOR, 32'h0000_00f1);
		rd_chk(BWSR_A_IO_TOP, 32'h0000_0001);
		rd_chk(BWSR_A_SEC_STS, 32'h0000_0000);
		rd_chk(BWSR_A_MEM_FLOOR, 32'h0000_fff0);
		rd_chk(BWSR_A_MEM_TOP, 32'h0000_0000);
	endtask

	// Top field writable, cap mirror read-only, cap lock honoured
	task automatic t_io_regs;
		wr(BWSR_A_IO_TOP, 32'hffff_fffe);
		rd_chk(BWSR_A_IO_TOP, 32'h0000_00f1);
		wr(BWSR_A_IO_FLOOR, 32'h0000_0020);
		rd_chk(BWSR_A_IO_FLOOR, 32'h0000_0021);
		wr(BWSR_A_CTRL, 32'h0000_0004);
		wr(BWSR_A_IO_FLOOR, 32'hffff_ff20);
		rd_chk(BWSR_A_IO_FLOOR, 32'h0000_0020);
		rd_chk(BWSR_A_IO_TOP, 32'h0000_00f0);
	endtask

	task automatic t_sec_status;
		wr(BWSR_A_CTRL, 32'h0000_0000);
		wr(BWSR_A_SEC_STS, 32'hffff_ffff);
		rd_chk(BWSR_A_SEC_STS, 32'h0000_0000);
		pulse(1'b1);
		rd_chk(BWSR_A_SEC_STS, 32'h0000_0000);
		wr(BWSR_A_CTRL, 32'h0000_0001);
		pulse(1'b1);
		rd_chk(BWSR_A_SEC_STS, 32'h0000_4000);
		wr(BWSR_A_SEC_STS, 32'h0000_0000);
		rd_chk(BWSR_A_SEC_STS, 32'h0000_4000);
		wr(BWSR_A_SEC_STS, 32'h0000_4000);
		rd_chk(BWSR_A_SEC_STS, 32'h0000_0000);
		pulse(1'b0);
		rd_chk(BWSR_A_SEC_STS, 32'h0000_8000);
		wr(BWSR_A_SEC_STS, 32'h0000_8000);
		rd_chk(BWSR_A_SEC_STS, 32'h0000_0000);
		// Parity response enable set: a poisoned packet must still flag
		wr(BWSR_A_CTRL, 32'h0000_0003);
		rd_chk(BWSR_A_CTRL, 32'h0000_0003);
		pulse(1'b0);
		rd_chk(BWSR_A_SEC_STS, 32'h0000_8000);
		wr(BWSR_A_SEC_STS, 32'h0000_8000);
		rd_chk(BWSR_A_SEC_STS, 32'h0000_0000);
	endtask

	// Status sticky, mask gates the level output, write-one clears
	task automatic t_irq;
		rd_chk(BWSR_A_INT_STAT, 32'h0000_0003);
		repeat (2) @(posedge clk_sys);
		`CHK("irq masked", 1'b0, irq)
		wr(BWSR_A_INT_MASK, 32'h0000_0002);
		repeat (2) @(posedge clk_sys);
		`CHK("irq on", 1'b1, irq)
		wr(BWSR_A_INT_STAT, 32'h0000_0002);
		repeat (2) @(posedge clk_sys);
		`CHK("irq off", 1'b0, irq)
		rd_chk(BWSR_A_INT_STAT, 32'h0000_0001);
		// System error path through the mask, then a fresh event
		wr(BWSR_A_INT_MASK, 32'h0000_0001);
		rd_chk(BWSR_A_INT_MASK, 32'h0000_0001);
		repeat (2) @(posedge clk_sys);
		`CHK("irq rse", 1'b1, irq)
		wr(BWSR_A_INT_STAT, 32'h0000_0001);
		repeat (2) @(posedge clk_sys);
		`CHK("irq clear", 1'b0, irq)
		pulse(1'b1);
		repeat (2) @(posedge clk_sys);
		`CHK("irq event", 1'b1, irq)
		wr(BWSR_A_SEC_STS, 32'h0000_4000);
		rd_chk(BWSR_A_SEC_STS, 32'h0000_0000);
	endtask

	// I/O window 0x2000..0x3fff, memory 0x1000_0000..0x110f_ffff
	task automatic t_forward;
		wr(BWSR_A_IO_TOP, 32'h0000_0030);
		wr(BWSR_A_MEM_FLOOR, 32'h0000_1000);
		wr(BWSR_A_MEM_TOP, 32'h0000_1100);
		fwd(32'h0000_1fff, 32'h0fff_ffff, 1'b0, 1'b0);
		fwd(32'h0000_2000, 32'h1000_0000, 1'b1, 1'b1);
		fwd(32'h0000_3fff, 32'h110f_ffff, 1'b1, 1'b1);
		fwd(32'h0000_4000, 32'h1110_0000, 1'b0, 1'b0);
		fwd(32'h0001_2000, 32'h1050_0000, 1'b0, 1'b1);
		wr(BWSR_A_IO_FLOOR, 32'h0000_0040);
		wr(BWSR_A_MEM_FLOOR, 32'h0000_1200);
		fwd(32'h0000_3800, 32'h1080_0000, 1'b0, 1'b0);
	endtask

	// Unmapped place, partial strobes, frozen clock enable
	task automatic t_refused;
		axi_wr(12'h200, 32'hffff_ffff, 4'hf, rsp);
		`CHK("bresp unmapped", BWSR_RESP_SLVERR, rsp)
		axi_rd(12'h200, rd, rsp);
		`CHK("rresp unmapped", BWSR_RESP_SLVERR, rsp)
		`CHK("rdata unmapped", 32'h0, rd)
		axi_wr(BWSR_A_MEM_FLOOR, 32'h0000_aaa0, 4'h1, rsp);
		rd_chk(BWSR_A_MEM_FLOOR, 32'h0000_12a0);
		@(posedge clk_sys);
		ce <= 1'b0;
		pulse(1'b0);
		@(posedge clk_sys);
		ce <= 1'b1;
		rd_chk(BWSR_A_SEC_STS, 32'h0000_0000);
	endtask

	task automatic stop_test;
		$display("Checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Main sequence: reset for four cycles, then the scenarios
	initial begin
		repeat (4) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		t_reset_vals();
		t_io_regs();
		t_sec_status();
		t_irq();
		t_forward();
		t_refused();
		stop_test();
	end

	// Watchdog: the whole run needs well under 20000 cycles
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_mismatch++;
		stop_test();
	end
endmodule
